/* design/flash_command_status_ctrl.sv */
// Flash command buffer, status flags, protection and lock registers behind AHB-Lite.
// Assumes the flash array runs on the same clock and answers load and command requests.
module flash_command_status_ctrl (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire fsc_pkg::bus_t haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire fsc_pkg::bus_t hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output fsc_pkg::bus_t hrdata_o,
  input wire logic special_mode_i,
  output logic load_req_o,
  input wire logic load_valid_i,
  input wire fsc_pkg::byte_t load_prot_i,
  input wire fsc_pkg::byte_t load_lock_i,
  output logic cmd_start_o,
  output fsc_pkg::byte_t cmd_code_o,
  output fsc_pkg::half_t cmd_addr_o,
  output fsc_pkg::half_t cmd_data_o,
  output logic cmd_abort_o,
  input wire logic cmd_done_i,
  input wire logic cmd_blank_i,
  input wire logic cmd_fail_i,
  output logic backdoor_en_o,
  output logic unsecured_o,
  output logic [3:0] user_flags_o,
  output logic buf_empty_irq_o,
  output logic complete_irq_o
);
  import fsc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic wr_hit(input logic wr, input idx_t a, input idx_t t);
    wr_hit = wr & (a == t);
  endfunction

  function automatic logic scen_ok(input scen_t from, input scen_t to);
    if (from == SCEN_ALL) begin
      scen_ok = 1'b1;
    end else if (from == SCEN_SIX) begin
      scen_ok = (to == 3'h1) | (to == 3'h3) | (to == 3'h4) | (to == 3'h6);
    end else begin
      scen_ok = (to == from);
    end
  endfunction

  // ==========================================================
  // State
  load_state_t ld_r, ld_nxt;
  logic dp_r, a_wr_r, a_map_r, hready_r;
  idx_t a_idx_r;
  bus_t hrdata_r;
  byte_t cfg_r, prot_r, lock_r, code_r;
  half_t addr_r, data_r;
  logic cbe_r, command_complete_flag_r, protection_breach_flag_r, access_error_flag_r, blank_r, fail_r;
  logic busy_r, pend_r, seq_word_r, seq_cmd_r;
  logic start_r, abort_r, load_req_r, bd_en_r, unsec_r, bei_r, cci_r;
  byte_t act_code_r;
  half_t act_addr_r, act_data_r;

  // ==========================================================
  // Bus decode
  wire take_w = hsel_i & htrans_i[1] & hready_i & (ld_r == LD_RUN);
  wire map_w = (haddr_i[31:8] == 24'h000000);
  wire wr_w = dp_r & a_wr_r & a_map_r;
  wire byte_t wd = hwdata_i[7:0];
  wire half_t wh = hwdata_i[15:0];
  wire st_wr = wr_hit(wr_w, a_idx_r, IDX_STAT);
  wire cfg_wr = wr_hit(wr_w, a_idx_r, IDX_CFG);
  wire prot_wr = wr_hit(wr_w, a_idx_r, IDX_PROT);
  wire cmd_wr = wr_hit(wr_w, a_idx_r, IDX_CMD);
  wire word_wr = wr_hit(wr_w, a_idx_r, IDX_WORD);
  wire addr_wr = wr_hit(wr_w, a_idx_r, IDX_ADDR);
  wire key_wr = wr_hit(wr_w, a_idx_r, IDX_KEY);

  // ==========================================================
  // Command sequence
  wire w1_cbe = st_wr & wd[ST_CBE];
  wire w0_cbe = st_wr & ~wd[ST_CBE];
  wire prot_block = (prot_r[PROT_SCEN_HI:0] != SCEN_ALL);
  wire seq_ok = seq_word_r & seq_cmd_r & ~(special_mode_i & fail_r);
  wire abort_seq = w0_cbe & cbe_r & seq_word_r;
  wire commit = w1_cbe & cbe_r & seq_ok & ~prot_block;
  wire breach = w1_cbe & cbe_r & seq_ok & prot_block;
  wire bad_commit = w1_cbe & cbe_r & ~seq_ok;
  wire full_wr = (word_wr | cmd_wr | addr_wr) & ~cbe_r;
  wire acc_set = abort_seq | bad_commit | full_wr;
  wire fetch = pend_r & (~busy_r | cmd_done_i);
  wire busy_nxt = fetch | (busy_r & ~cmd_done_i);
  wire pend_nxt = commit | (pend_r & ~fetch);
  wire cbe_nxt = fetch | (cbe_r & ~commit);
  wire command_complete_flag_nxt = cbe_nxt & ~busy_nxt & ~pend_nxt;
  wire protection_breach_flag_nxt = breach | (protection_breach_flag_r & ~(st_wr & wd[ST_PROTECTION_BREACH_FLAG]));
  wire access_error_flag_nxt = acc_set | (access_error_flag_r & ~(st_wr & wd[ST_ACCESS_ERROR_FLAG]));
  wire blank_nxt = (busy_r & cmd_done_i & cmd_blank_i) | (blank_r & ~commit);
  wire fail_clr = st_wr & special_mode_i & wd[ST_FAIL];
  wire fail_nxt = (busy_r & cmd_done_i & cmd_fail_i) | (fail_r & ~fail_clr);
  wire byte_t cfg_nxt = cfg_wr ? wd : cfg_r;

  // ==========================================================
  // Register read mux
  wire done_w = ~busy_r & ~pend_r;
  wire byte_t stat_rd = {cbe_r, command_complete_flag_r, protection_breach_flag_r, access_error_flag_r, 1'b0, blank_r,
                         special_mode_i & fail_r, special_mode_i & done_w};
  byte_t rd_mux;
  always_comb begin
    if (!a_map_r) begin
      rd_mux = 8'h00;
    end else if (a_idx_r == IDX_LOCK) begin
      rd_mux = lock_r;
    end else if (a_idx_r == IDX_CFG) begin
      rd_mux = cfg_r;
    end else if (a_idx_r == IDX_PROT) begin
      rd_mux = prot_r;
    end else if (a_idx_r == IDX_STAT) begin
      rd_mux = stat_rd;
    end else if (a_idx_r == IDX_CMD) begin
      rd_mux = code_r;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ==========================================================
  // Reset load sequence
  always_comb begin
    ld_nxt = ld_r;
    case (ld_r)
      LD_REQ: ld_nxt = LD_WAIT;
      LD_WAIT: if (load_valid_i) ld_nxt = LD_RUN;
      LD_RUN: ld_nxt = LD_RUN;
      default: ld_nxt = LD_REQ;
    endcase
  end

  // ==========================================================
  // Bus slave, one wait state per transfer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dp_r <= 1'b0;
      a_wr_r <= 1'b0;
      a_map_r <= 1'b0;
      a_idx_r <= 6'h00;
      hready_r <= 1'b0;
      hrdata_r <= 32'h00000000;
    end else begin
      dp_r <= take_w;
      if (take_w) begin
        a_wr_r <= hwrite_i;
        a_map_r <= map_w;
        a_idx_r <= haddr_i[7:2];
      end
      hready_r <= (ld_nxt == LD_RUN) & ~take_w;
      if (dp_r & ~a_wr_r) begin
        hrdata_r <= {24'h000000, rd_mux};
      end
    end
  end

  // ==========================================================
  // Load, protection, lock and configuration
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ld_r <= LD_REQ;
      load_req_r <= 1'b0;
      prot_r <= PROT_RST;
      lock_r <= LOCK_RST;
      cfg_r <= CFG_RST;
    end else begin
      ld_r <= ld_nxt;
      load_req_r <= (ld_nxt == LD_WAIT);
      cfg_r <= cfg_nxt;
      if (ld_r == LD_WAIT && load_valid_i) begin
        prot_r <= load_prot_i;
        lock_r <= load_lock_i;
      end else begin
        if (prot_wr && scen_ok(prot_r[PROT_SCEN_HI:0], wd[PROT_SCEN_HI:0])) begin
          prot_r[PROT_SCEN_HI:0] <= wd[PROT_SCEN_HI:0];
        end
        if (key_wr && wd == BACKDOOR_KEY && lock_r[LOCK_KEY_HI:LOCK_KEY_LO] == BACKDOOR_KEY_ENABLE_ON) begin
          lock_r[LOCK_SEC_HI:0] <= SEC_OPEN;
        end
      end
    end
  end

  // ==========================================================
  // Status flags and command buffer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cbe_r <= 1'b1;
      command_complete_flag_r <= 1'b1;
      protection_breach_flag_r <= 1'b0;
      access_error_flag_r <= 1'b0;
      blank_r <= 1'b0;
      fail_r <= 1'b0;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      seq_word_r <= 1'b0;
      seq_cmd_r <= 1'b0;
      code_r <= 8'h00;
      addr_r <= 16'h0000;
      data_r <= 16'h0000;
    end else begin
      cbe_r <= cbe_nxt;
      command_complete_flag_r <= command_complete_flag_nxt;
      protection_breach_flag_r <= protection_breach_flag_nxt;
      access_error_flag_r <= access_error_flag_nxt;
      blank_r <= blank_nxt;
      fail_r <= fail_nxt;
      busy_r <= busy_nxt;
      pend_r <= pend_nxt;
      // Any one-write to the empty flag ends the sequence, launched or refused
      if ((w1_cbe && cbe_r) || abort_seq) begin
        seq_word_r <= 1'b0;
        seq_cmd_r <= 1'b0;
      end else if (cbe_r) begin
        if (word_wr) begin
          seq_word_r <= 1'b1;
          data_r <= wh;
        end
        if (addr_wr) begin
          addr_r <= wh;
        end
        if (cmd_wr && seq_word_r) begin
          seq_cmd_r <= 1'b1;
          code_r <= wd;
        end
      end
    end
  end

  // ==========================================================
  // Array command port and status outputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      abort_r <= busy_r;
      start_r <= 1'b0;
      act_code_r <= 8'h00;
      act_addr_r <= 16'h0000;
      act_data_r <= 16'h0000;
      bd_en_r <= 1'b0;
      unsec_r <= 1'b0;
      bei_r <= 1'b0;
      cci_r <= 1'b0;
    end else begin
      abort_r <= 1'b0;
      start_r <= fetch;
      if (fetch) begin
        act_code_r <= code_r;
        act_addr_r <= addr_r;
        act_data_r <= data_r;
      end
      bd_en_r <= (lock_r[LOCK_KEY_HI:LOCK_KEY_LO] == BACKDOOR_KEY_ENABLE_ON);
      unsec_r <= (lock_r[LOCK_SEC_HI:0] == SEC_OPEN);
      bei_r <= cbe_nxt & cfg_nxt[CFG_CBE_IE];
      cci_r <= command_complete_flag_nxt & cfg_nxt[CFG_CC_IE];
    end
  end

  assign hreadyout_o = hready_r;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;
  assign load_req_o = load_req_r;
  assign cmd_start_o = start_r;
  assign cmd_code_o = act_code_r;
  assign cmd_addr_o = act_addr_r;
  assign cmd_data_o = act_data_r;
  assign cmd_abort_o = abort_r;
  assign backdoor_en_o = bd_en_r;
  assign unsecured_o = unsec_r;
  assign user_flags_o = lock_r[LOCK_NV_HI:LOCK_NV_LO];
  assign buf_empty_irq_o = bei_r;
  assign complete_irq_o = cci_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  property p_backdoor_key_enable;
    ##1 backdoor_en_o == ($past(lock_r[LOCK_KEY_HI:LOCK_KEY_LO]) == BACKDOOR_KEY_ENABLE_ON);
  endproperty
  a_backdoor_key_enable: assert property (p_backdoor_key_enable) else $error("backdoor enable wrong");

  property p_secure;
    ##1 unsecured_o == ($past(lock_r[LOCK_SEC_HI:0]) == SEC_OPEN);
  endproperty
  a_secure: assert property (p_secure) else $error("unsecured output wrong");

  sequence s_key_ok;
    key_wr && wd == BACKDOOR_KEY && lock_r[LOCK_KEY_HI:LOCK_KEY_LO] == BACKDOOR_KEY_ENABLE_ON
      && ld_r == LD_RUN;
  endsequence
  property p_backdoor;
    s_key_ok |=> lock_r[LOCK_SEC_HI:0] == SEC_OPEN ##1 unsecured_o;
  endproperty
  a_backdoor: assert property (p_backdoor) else $error("backdoor did not unlock");

  property p_rsvd;
    dp_r && !a_wr_r && (a_idx_r == IDX_RSVD2 || a_idx_r == IDX_RSVD13
      || a_idx_r == IDX_RSVD14) |=> hrdata_o == 32'h00000000 && hreadyout_o;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved register not zero");

  property p_scen_six;
    prot_wr && prot_r[PROT_SCEN_HI:0] == SCEN_SIX && ld_r == LD_RUN
      && (wd[PROT_SCEN_HI:0] == 3'h0 || wd[PROT_SCEN_HI:0] == 3'h2
      || wd[PROT_SCEN_HI:0] == 3'h5 || wd[PROT_SCEN_HI:0] == 3'h7)
      |=> prot_r[PROT_SCEN_HI:0] == SCEN_SIX;
  endproperty
  a_scen_six: assert property (p_scen_six) else $error("illegal scenario taken");

  property p_normal_bits;
    dp_r && !a_wr_r && a_map_r && a_idx_r == IDX_STAT && !special_mode_i
      |=> hrdata_o[3] == 1'b0 && hrdata_o[ST_FAIL] == 1'b0 && hrdata_o[ST_DONE] == 1'b0;
  endproperty
  a_normal_bits: assert property (p_normal_bits) else $error("status reserved bit set");

  property p_w0_cbe;
    w0_cbe && !fetch |=> $stable(cbe_r);
  endproperty
  a_w0_cbe: assert property (p_w0_cbe) else $error("zero write changed empty flag");

  property p_abort;
    abort_seq |=> access_error_flag_r && !seq_word_r && !pend_r;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not flag error");

  property p_no_err;
    w0_cbe && !seq_word_r && !access_error_flag_r |=> !access_error_flag_r;
  endproperty
  a_no_err: assert property (p_no_err) else $error("error set outside sequence");

  property p_command_complete_flag_clear;
    !cbe_r |-> !command_complete_flag_r;
  endproperty
  a_command_complete_flag_clear: assert property (p_command_complete_flag_clear) else $error("complete while buffer full");

  sequence s_last_done;
    busy_r && cmd_done_i && !pend_r && cbe_r && !commit;
  endsequence
  property p_command_complete_flag_set;
    s_last_done |=> command_complete_flag_r ##1 (command_complete_flag_r || !cbe_r || busy_r);
  endproperty
  a_command_complete_flag_set: assert property (p_command_complete_flag_set) else $error("complete flag not set");

  property p_command_complete_flag_pend;
    busy_r && cmd_done_i && pend_r |=> !command_complete_flag_r && busy_r && cmd_start_o;
  endproperty
  a_command_complete_flag_pend: assert property (p_command_complete_flag_pend) else $error("complete set on fetch");

  property p_stall;
    ld_r != LD_RUN |-> !hreadyout_o;
  endproperty
  a_stall: assert property (p_stall) else $error("bus not stalled during load");

  property p_irq;
    buf_empty_irq_o == (cbe_r & cfg_r[CFG_CBE_IE])
      && complete_irq_o == (command_complete_flag_r & cfg_r[CFG_CC_IE]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch");

endmodule

/* design/fsc_pkg.sv */
// Constants, types and register map of the flash command and status controller.
// Assumes one 40 MHz bus clock, synchronous active-high reset and an AHB-Lite master.
package fsc_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [15:0] half_t;
  typedef logic [31:0] bus_t;
  typedef logic [5:0] idx_t;
  typedef logic [2:0] scen_t;

  typedef enum logic [2:0] {
    LD_REQ = 3'b001,
    LD_WAIT = 3'b010,
    LD_RUN = 3'b100
  } load_state_t;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam idx_t IDX_LOCK = 6'h01;
  localparam idx_t IDX_RSVD2 = 6'h02;
  localparam idx_t IDX_CFG = 6'h03;
  localparam idx_t IDX_PROT = 6'h04;
  localparam idx_t IDX_STAT = 6'h05;
  localparam idx_t IDX_CMD = 6'h06;
  localparam idx_t IDX_WORD = 6'h08;
  localparam idx_t IDX_ADDR = 6'h09;
  localparam idx_t IDX_KEY = 6'h0A;
  localparam idx_t IDX_RSVD13 = 6'h0D;
  localparam idx_t IDX_RSVD14 = 6'h0E;

  // ==========================================================
  // Field positions
  localparam int ST_CBE = 7;
  localparam int ST_COMMAND_COMPLETE_FLAG = 6;
  localparam int ST_PROTECTION_BREACH_FLAG = 5;
  localparam int ST_ACCESS_ERROR_FLAG = 4;
  localparam int ST_BLANK = 2;
  localparam int ST_FAIL = 1;
  localparam int ST_DONE = 0;
  localparam int CFG_CBE_IE = 7;
  localparam int CFG_CC_IE = 6;
  localparam int LOCK_KEY_HI = 7;
  localparam int LOCK_KEY_LO = 6;
  localparam int LOCK_NV_HI = 5;
  localparam int LOCK_NV_LO = 2;
  localparam int LOCK_SEC_HI = 1;
  localparam int PROT_SCEN_HI = 2;

  // ==========================================================
  // Codes and reset values
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON = 2'h2;
  localparam logic [1:0] SEC_OPEN = 2'h2;
  localparam scen_t SCEN_ALL = 3'h7;
  localparam scen_t SCEN_SIX = 3'h6;
  localparam byte_t CFG_RST = 8'h00;
  localparam byte_t PROT_RST = 8'hFF;
  localparam byte_t LOCK_RST = 8'hFF;
  // Arbitrary value, not tied to any part
  localparam byte_t BACKDOOR_KEY = 8'hA5;

endpackage

/* test/flash_array_model.sv */
// Behavioural flash array facing the command and status controller.
// Assumes the controller's clock and reset; images and qualifiers come from the bench.
module flash_array_model
  import fsc_pkg::*;
#(
  parameter int LOAD_DLY = 5,
  parameter int CMD_DLY = 60
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic load_req_i,
  input wire logic cmd_start_i,
  input wire fsc_pkg::byte_t prot_img_i,
  input wire fsc_pkg::byte_t lock_img_i,
  input wire logic blank_i,
  input wire logic fail_i,
  output logic load_valid_o,
  output fsc_pkg::byte_t load_prot_o,
  output fsc_pkg::byte_t load_lock_o,
  output logic cmd_done_o,
  output logic cmd_blank_o,
  output logic cmd_fail_o
);
  int lcnt;
  int ccnt;
  logic busy_r;

  // ==========================================================
  // Images and qualifiers carry garbage outside their valid cycle
  assign load_prot_o = load_valid_o ? prot_img_i : ~prot_img_i;
  assign load_lock_o = load_valid_o ? lock_img_i : ~lock_img_i;
  assign cmd_blank_o = cmd_done_o ? blank_i : ~blank_i;
  assign cmd_fail_o = cmd_done_o ? fail_i : ~fail_i;

  // ==========================================================
  // Load answers after a delay; commands finish after a delay
  always_ff @(posedge clock_i) begin
    load_valid_o <= 1'b0;
    cmd_done_o <= 1'b0;
    if (rst_i) begin
      lcnt <= 0;
      ccnt <= 0;
      busy_r <= 1'b0;
    end else begin
      if (load_req_i && !load_valid_o) begin
        lcnt <= lcnt + 1;
        if (lcnt == LOAD_DLY) begin
          lcnt <= 0;
          load_valid_o <= 1'b1;
        end
      end
      if (cmd_start_i) begin
        busy_r <= 1'b1;
        ccnt <= 0;
      end else if (busy_r) begin
        ccnt <= ccnt + 1;
        if (ccnt == CMD_DLY) begin
          busy_r <= 1'b0;
          cmd_done_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* test/flash_command_status_ctrl_tb_top.sv */
// Self-checking bench for the flash command and status controller.
// Assumes an AHB-Lite master in the bench and the behavioural flash array model.
module flash_command_status_ctrl_tb_top import fsc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, special = 1'b0;
  logic blank = 1'b0, fail = 1'b0, hreadyout, hresp, load_req, load_valid;
  logic cmd_start, cmd_abort, cmd_done, cmd_blank, cmd_fail, backdoor_en, unsecured;
  logic be_irq, cc_irq;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [3:0] user_flags;
  bus_t haddr = '0, hwdata = '0, hrdata;
  byte_t prot_img = 8'hFF, lock_img = 8'hFF, load_prot, load_lock, cmd_code;
  half_t cmd_addr, cmd_data;
  int errors = 0, n_compared = 0, cycles = 0;
  idx_t rsv[3] = '{IDX_RSVD2, IDX_RSVD13, IDX_RSVD14};
  scen_t sw[4] = '{3'h6, 3'h2, 3'h3, 3'h1};
  scen_t se[4] = '{3'h6, 3'h6, 3'h3, 3'h3};

  always #12.5 clock = ~clock;

  flash_command_status_ctrl dut (.clock_i(clock), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .special_mode_i(special), .load_req_o(load_req), .load_valid_i(load_valid),
    .load_prot_i(load_prot), .load_lock_i(load_lock), .cmd_start_o(cmd_start),
    .cmd_code_o(cmd_code), .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data),
    .cmd_abort_o(cmd_abort), .cmd_done_i(cmd_done), .cmd_blank_i(cmd_blank),
    .cmd_fail_i(cmd_fail), .backdoor_en_o(backdoor_en), .unsecured_o(unsecured),
    .user_flags_o(user_flags), .buf_empty_irq_o(be_irq), .complete_irq_o(cc_irq));

  flash_array_model array (.clock_i(clock), .rst_i(rst), .load_req_i(load_req),
    .cmd_start_i(cmd_start), .prot_img_i(prot_img), .lock_img_i(lock_img), .blank_i(blank),
    .fail_i(fail), .load_valid_o(load_valid), .load_prot_o(load_prot),
    .load_lock_o(load_lock), .cmd_done_o(cmd_done), .cmd_blank_o(cmd_blank),
    .cmd_fail_o(cmd_fail));

  // ==========================================================
  // Compare, bus and sequence tasks
  task automatic chk16(input half_t got, input half_t exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input bus_t a, input half_t wd, output byte_t rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata[7:0];
  endtask

  task automatic wr(input idx_t i, input half_t d);
    byte_t x;
    bus(1'b1, {24'h000000, i, 2'b00}, d, x);
  endtask

  task automatic rd(input idx_t i, output byte_t x);
    bus(1'b0, {24'h000000, i, 2'b00}, 16'h0000, x);
  endtask

  task automatic rchk(input idx_t i, input byte_t exp);
    byte_t x;
    rd(i, x);
    chk16({8'h00, x}, {8'h00, exp});
  endtask

  task automatic wait_hi(input int w);
    logic s;
    s = 1'b0;
    while (s !== 1'b1) begin
      @(posedge clock);
      case (w)
        0: s = load_req;
        1: s = hreadyout;
        2: s = cmd_start;
        3: s = cmd_done;
        default: s = cc_irq;
      endcase
    end
  endtask

  task automatic do_reset(input logic chk, input logic exp);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    if (chk) chk1(cmd_abort, exp);
    rst <= 1'b0;
    wait_hi(0);
    chk1(hreadyout, 1'b0);
    wait_hi(1);
    @(posedge clock);
  endtask

  task automatic cmd(input byte_t c, input half_t a, input half_t d);
    wr(IDX_WORD, d);
    wr(IDX_ADDR, a);
    wr(IDX_CMD, {8'h00, c});
    wr(IDX_STAT, 16'h0080);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [1:0] k;
    byte_t v;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i + 3);
      lock_img = {k, 4'h5, k};
      do_reset(i > 0, 1'b0);
      chk1(backdoor_en, k == 2'b10);
      chk1(unsecured, k == 2'b10);
      chk16({12'h000, user_flags}, 16'h0005);
      rchk(IDX_LOCK, lock_img);
    end
    lock_img = 8'h94;
    do_reset(1'b1, 1'b0);
    chk1(backdoor_en, 1'b1);
    chk1(unsecured, 1'b0);
    wr(IDX_KEY, 16'h00A5);
    rchk(IDX_LOCK, 8'h96);
    chk1(unsecured, 1'b1);
    foreach (rsv[j]) begin
      wr(rsv[j], 16'h00FF);
      rchk(rsv[j], 8'h00);
    end
    bus(1'b1, 32'h0000_0114, 16'h00FF, v);
    bus(1'b0, 32'h0000_0114, 16'h0000, v);
    chk16({8'h00, v}, 16'h0000);
    chk1(hresp, 1'b0);
    rchk(IDX_STAT, 8'hC0);
    wr(IDX_STAT, 16'h0000);
    rchk(IDX_STAT, 8'hC0);
    wr(IDX_STAT, 16'h0040);
    rchk(IDX_STAT, 8'hC0);
    wr(IDX_CFG, 16'h00C0);
    rchk(IDX_CFG, 8'hC0);
    chk1(be_irq, 1'b1);
    chk1(cc_irq, 1'b1);
    wr(IDX_WORD, 16'h1111);
    wr(IDX_STAT, 16'h0000);
    rchk(IDX_STAT, 8'hD0);
    wr(IDX_STAT, 16'h0010);
    rchk(IDX_STAT, 8'hC0);
    special <= 1'b1;
    rchk(IDX_STAT, 8'hC1);
    fail <= 1'b1;
    cmd(8'h20, 16'h0100, 16'h5A5A);
    wait_hi(3);
    fail <= 1'b0;
    rchk(IDX_STAT, 8'hC3);
    wr(IDX_STAT, 16'h0001);
    rchk(IDX_STAT, 8'hC3);
    wr(IDX_STAT, 16'h0002);
    rchk(IDX_STAT, 8'hC1);
    special <= 1'b0;
    rchk(IDX_STAT, 8'hC0);
    blank <= 1'b1;
    cmd(8'h20, 16'h1234, 16'hBEEF);
    cmd(8'h41, 16'h0010, 16'hCAFE);
    rchk(IDX_STAT, 8'h00);
    chk1(be_irq, 1'b0);
    chk1(cc_irq, 1'b0);
    wait_hi(2);
    rchk(IDX_STAT, 8'h84);
    chk16({8'h00, cmd_code}, 16'h0041);
    chk16(cmd_addr, 16'h0010);
    chk16(cmd_data, 16'hCAFE);
    chk1(be_irq, 1'b1);
    wait_hi(4);
    rchk(IDX_STAT, 8'hC4);
    wr(IDX_STAT, 16'h0004);
    rchk(IDX_STAT, 8'hC4);
    wr(IDX_CFG, 16'h0080);
    rchk(IDX_CFG, 8'h80);
    chk1(cc_irq, 1'b0);
    chk1(be_irq, 1'b1);
    blank <= 1'b0;
    cmd(8'h20, 16'h0200, 16'h0001);
    do_reset(1'b1, 1'b1);
    foreach (sw[j]) begin
      wr(IDX_PROT, {8'h00, 5'h1F, sw[j]});
      rd(IDX_PROT, v);
      chk16({13'h0000, v[2:0]}, {13'h0000, se[j]});
    end
    cmd(8'h20, 16'h0300, 16'h0002);
    rchk(IDX_STAT, 8'hE0);
    wr(IDX_STAT, 16'h0020);
    rchk(IDX_STAT, 8'hC0);
    tally_and_finish();
  end
endmodule
